// file: src/kei_map.svh
`ifndef KEI_MAP_SVH
`define KEI_MAP_SVH
// register byte addresses on the apb bus
`define KEI_ADDR_SCR 12'h000
`define KEI_ADDR_KEN 12'h004
// status and control field positions
`define KEI_SCR_KEY_SENS 0
`define KEI_SCR_MASKK 1
`define KEI_SCR_KEY_ACK 2
`define KEI_SCR_KEY_FLAG 3
`define KEI_SCR_EXT_SENS 4
`define KEI_SCR_MASKI 5
`define KEI_SCR_EXT_ACK 6
`define KEI_SCR_EXT_FLAG 7
// reset values
`define KEI_SCR_RESET 8'h00
`define KEI_KEN_RESET 6'h00
`endif

// file: src/kei_pkg.sv
package kei_pkg;
  typedef enum logic [1:0] {
    KEI_REG_SCR = 2'b00,
    KEI_REG_KEN = 2'b01,
    KEI_REG_NONE = 2'b10
  } kei_reg_t;
endpackage

// file: src/kei_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "kei_map.svh"

module kei_unit #(
  parameter int NKEY = 6
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins and port control
  input wire logic EXT_PIN_N,
  input wire logic [NKEY-1:0] KEY_PIN,
  input wire logic [NKEY-1:0] PORT_DIR,
  output logic [NKEY-1:0] KEY_PULLUP_EN,
  output logic [NKEY-1:0] KEY_DIR_EFF,
  // system integration
  input wire logic VECTOR_FETCH,
  input wire logic BREAK_STATE,
  input wire logic BREAK_CLEAR_ENABLE,
  output logic EXT_IRQ_REQ,
  output logic KEY_IRQ_REQ
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic ext_meta_q;
  logic ext_sync_q;
  logic [NKEY-1:0] key_meta_q;
  logic [NKEY-1:0] key_sync_q;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
      key_meta_q <= '1;
      key_sync_q <= '1;
    end else begin
      ext_meta_q <= EXT_PIN_N;
      ext_sync_q <= ext_meta_q;
      key_meta_q <= KEY_PIN;
      key_sync_q <= key_meta_q;
    end
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  kei_pkg::kei_reg_t reg_sel;
  logic wr_stb;
  logic ack_ok;

  always_comb begin
    unique case (PADDR)
      `KEI_ADDR_SCR: reg_sel = kei_pkg::KEI_REG_SCR;
      `KEI_ADDR_KEN: reg_sel = kei_pkg::KEI_REG_KEN;
      default: reg_sel = kei_pkg::KEI_REG_NONE;
    endcase
  end

  assign wr_stb = PSEL && PENABLE && PWRITE;
  // zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (reg_sel == kei_pkg::KEI_REG_NONE);
  // break blocks software clears unless enabled
  assign ack_ok = !BREAK_STATE || BREAK_CLEAR_ENABLE;

  logic scr_wr;
  logic ken_wr;
  logic ext_sw_ack;
  logic key_sw_ack;
  assign scr_wr = wr_stb && (reg_sel == kei_pkg::KEI_REG_SCR);
  assign ken_wr = wr_stb && (reg_sel == kei_pkg::KEI_REG_KEN);
  assign ext_sw_ack = scr_wr && PWDATA[`KEI_SCR_EXT_ACK] && ack_ok;
  assign key_sw_ack = scr_wr && PWDATA[`KEI_SCR_KEY_ACK] && ack_ok;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic mask_e_q;
  logic mode_e_q;
  logic mask_k_q;
  logic mode_k_q;
  logic [NKEY-1:0] key_en_q;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_e_q <= 1'b0;
      mode_e_q <= 1'b0;
      mask_k_q <= 1'b0;
      mode_k_q <= 1'b0;
    end else if (scr_wr) begin
      mask_e_q <= PWDATA[`KEI_SCR_MASKI];
      mode_e_q <= PWDATA[`KEI_SCR_EXT_SENS];
      mask_k_q <= PWDATA[`KEI_SCR_MASKK];
      mode_k_q <= PWDATA[`KEI_SCR_KEY_SENS];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      key_en_q <= NKEY'(`KEI_KEN_RESET);
    end else if (ken_wr) begin
      key_en_q <= PWDATA[NKEY-1:0];
    end
  end

  assign KEY_PULLUP_EN = key_en_q;
  // enabled keypad pins are forced to input
  assign KEY_DIR_EFF = PORT_DIR & ~key_en_q;

  // ------------------------------------------------------------
  // external pin latch
  // ------------------------------------------------------------
  logic ext_prev_q;
  logic ext_latch_q;
  logic ext_fall;
  logic ext_ack;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_fall = ext_prev_q && !ext_sync_q;
  assign ext_ack = VECTOR_FETCH || ext_sw_ack;

  // set beats clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_latch_q <= 1'b0;
    end else if (ext_fall) begin
      ext_latch_q <= 1'b1;
    end else if (ext_ack) begin
      ext_latch_q <= 1'b0;
    end
  end

  // pin still low since the latched edge; keeps a level request alive
  // after an early ack, so ack and release may come in any order
  logic ext_hold_q;
  logic ext_pend;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_hold_q <= 1'b0;
    end else if (ext_fall) begin
      ext_hold_q <= 1'b1;
    end else if (ext_sync_q) begin
      ext_hold_q <= 1'b0;
    end
  end

  assign ext_pend = ext_latch_q || (mode_e_q && ext_hold_q);

  // ------------------------------------------------------------
  // keypad latch
  // ------------------------------------------------------------
  logic key_all_high;
  logic key_prev_q;
  logic key_latch_q;
  logic key_fall;
  logic key_ack;

  // and of the enabled pins; disabled pins count as high
  assign key_all_high = &(key_sync_q | ~key_en_q);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      key_prev_q <= 1'b1;
    end else begin
      key_prev_q <= key_all_high;
    end
  end

  // only the first pin to drop gives an edge
  assign key_fall = key_prev_q && !key_all_high;
  assign key_ack = VECTOR_FETCH || key_sw_ack;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      key_latch_q <= 1'b0;
    end else if (key_fall) begin
      key_latch_q <= 1'b1;
    end else if (key_ack) begin
      key_latch_q <= 1'b0;
    end
  end

  // same idea as the external pin: in level mode an ack while a pin is low is not lost
  // all enabled pins returning high finishes the clear
  logic key_hold_q;
  logic key_pend;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      key_hold_q <= 1'b0;
    end else if (key_fall) begin
      key_hold_q <= 1'b1;
    end else if (key_all_high) begin
      key_hold_q <= 1'b0;
    end
  end

  assign key_pend = key_latch_q || (mode_k_q && key_hold_q);

  // ------------------------------------------------------------
  // requests and read data
  // ------------------------------------------------------------
  // no clock gating here, so wait and stop keep the requests alive
  assign EXT_IRQ_REQ = ext_pend && !mask_e_q;
  assign KEY_IRQ_REQ = key_pend && !mask_k_q;

  logic [7:0] scr_rd;
  always_comb begin
    scr_rd = `KEI_SCR_RESET;
    scr_rd[`KEI_SCR_EXT_FLAG] = ext_pend;
    scr_rd[`KEI_SCR_MASKI] = mask_e_q;
    scr_rd[`KEI_SCR_EXT_SENS] = mode_e_q;
    scr_rd[`KEI_SCR_KEY_FLAG] = key_pend;
    scr_rd[`KEI_SCR_MASKK] = mask_k_q;
    scr_rd[`KEI_SCR_KEY_SENS] = mode_k_q;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (reg_sel)
        kei_pkg::KEI_REG_SCR: PRDATA <= {24'h00_0000, scr_rd};
        kei_pkg::KEI_REG_KEN: PRDATA <= {{(32-NKEY){1'b0}}, key_en_q};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence key_sw_ack_seq;
    scr_wr && PWDATA[`KEI_SCR_KEY_ACK] && ack_ok;
  endsequence
  sequence key_pins_high_seq;
    key_all_high && !key_fall;
  endsequence
  sequence ext_sw_ack_seq;
    scr_wr && PWDATA[`KEI_SCR_EXT_ACK] && ack_ok;
  endsequence

  chk_break_block: assert property (@(posedge MCLK) disable iff (!RST_N)
    (scr_wr && BREAK_STATE && !BREAK_CLEAR_ENABLE && !VECTOR_FETCH && ext_latch_q)
      |=> ext_latch_q)
    else $error("external latch cleared during protected break");
  chk_break_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    (scr_wr && PWDATA[`KEI_SCR_KEY_ACK] && BREAK_STATE && BREAK_CLEAR_ENABLE
      && !key_fall && !mode_k_q) |=> !key_latch_q)
    else $error("keypad latch not cleared by break ack");
  chk_key_edge: assert property (@(posedge MCLK) disable iff (!RST_N)
    key_fall |=> key_latch_q)
    else $error("keypad falling edge not latched");
  chk_edge_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!mode_k_q && VECTOR_FETCH && !key_fall) |=> !key_latch_q)
    else $error("edge mode keypad request not cleared");
  chk_level_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    (mode_k_q && key_pend && !key_all_high && !scr_wr) |=> key_pend)
    else $error("level mode request dropped while pin low");
  chk_key_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
    KEY_IRQ_REQ |-> (key_pend && !mask_k_q))
    else $error("masked keypad request reached cpu");
  chk_ext_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
    (ext_latch_q && !mask_e_q) |-> EXT_IRQ_REQ)
    else $error("unmasked external request missing");
  chk_ext_edge: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(ext_sync_q) |=> ext_latch_q)
    else $error("external falling edge not latched");
  chk_pin_input: assert property (@(posedge MCLK) disable iff (!RST_N)
    (KEY_DIR_EFF & key_en_q) == '0)
    else $error("enabled keypad pin left as output");

  // level mode and edge gating
  chk_level_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    (mode_k_q && !key_latch_q) ##0 key_pins_high_seq |=> !key_pend)
    else $error("level mode request stayed after ack and release");
  chk_ack_while_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    key_sw_ack_seq ##0 (PWDATA[`KEI_SCR_KEY_SENS] && key_hold_q && !key_all_high)
      |=> key_pend)
    else $error("level mode request lost on early ack");
  chk_hold_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    key_all_high |=> !key_hold_q)
    else $error("keypad hold kept with all pins high");
  chk_edge_blocked: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!key_prev_q && !key_all_high && !key_latch_q) |=> !key_latch_q)
    else $error("keypad edge latched while a pin was already low");
  chk_ack_then_edge: assert property (@(posedge MCLK) disable iff (!RST_N)
    key_sw_ack_seq ##[1:40] key_fall |=> key_latch_q)
    else $error("edge after keypad ack not latched");

  // external pin
  chk_ext_ack: assert property (@(posedge MCLK) disable iff (!RST_N)
    ext_sw_ack_seq ##0 !ext_fall |=> !ext_latch_q)
    else $error("external ack did not clear the latch");
  chk_ext_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    (mode_e_q && ext_pend && !ext_sync_q && !scr_wr) |=> ext_pend)
    else $error("external level request dropped while pin low");
  chk_ext_hold_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    ext_sync_q |=> !ext_hold_q)
    else $error("external hold kept with pin high");
  chk_ext_fetch: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!mode_e_q && VECTOR_FETCH && !ext_fall && !scr_wr) |=> !ext_pend)
    else $error("edge mode external request not cleared by fetch");
  chk_vector_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    (VECTOR_FETCH && !ext_fall && !key_fall) |=> (!ext_latch_q && !key_latch_q))
    else $error("vector fetch left a latch set");

  // read back and port side
  chk_flag_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    (PSEL && !PENABLE && !PWRITE && reg_sel == kei_pkg::KEI_REG_SCR)
      |=> ((PRDATA[`KEI_SCR_KEY_FLAG] == $past(key_pend))
        && (PRDATA[`KEI_SCR_EXT_FLAG] == $past(ext_pend))))
    else $error("pending flags read back wrong");
  chk_ack_reads_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (PSEL && !PENABLE && !PWRITE && reg_sel == kei_pkg::KEI_REG_SCR)
      |=> (!PRDATA[`KEI_SCR_EXT_ACK] && !PRDATA[`KEI_SCR_KEY_ACK]))
    else $error("acknowledge bit read back as one");
  chk_pullup_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
    ken_wr |=> (KEY_PULLUP_EN == $past(PWDATA[NKEY-1:0])))
    else $error("pullups do not follow pin enables");
  chk_dir_passthru: assert property (@(posedge MCLK) disable iff (!RST_N)
    ((KEY_DIR_EFF ^ PORT_DIR) & ~key_en_q) == '0)
    else $error("disabled pin direction altered");
  chk_key_req_on: assert property (@(posedge MCLK) disable iff (!RST_N)
    (key_pend && !mask_k_q) |-> KEY_IRQ_REQ)
    else $error("unmasked keypad request missing");

  // break gating
  chk_key_break_block: assert property (@(posedge MCLK) disable iff (!RST_N)
    (scr_wr && BREAK_STATE && !BREAK_CLEAR_ENABLE && !VECTOR_FETCH && key_latch_q)
      |=> key_latch_q)
    else $error("keypad latch cleared during protected break");
  chk_no_ack_break: assert property (@(posedge MCLK) disable iff (!RST_N)
    (BREAK_STATE && !BREAK_CLEAR_ENABLE) |-> (!ext_sw_ack && !key_sw_ack))
    else $error("software ack passed during protected break");

endmodule // kei_unit
`default_nettype wire

// file: bench/kei_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module kei_pad_model #(
  parameter int NKEY = 6
) (
  // switch commands from the bench
  input wire logic [NKEY-1:0] press,
  input wire logic ext_press,
  // pin levels seen by the unit
  output logic [NKEY-1:0] key_pin,
  output logic ext_pin_n
);
  // an open switch leaves its pin on the pullup, so it reads high
  assign key_pin = ~press;
  assign ext_pin_n = ~ext_press;
endmodule // kei_pad_model

`default_nettype wire

// file: bench/keypad_ext_interrupt_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "kei_map.svh"

module keypad_ext_interrupt_unit_tb;
  localparam logic [31:0] mok = 32'h1 << `KEI_SCR_KEY_SENS;
  localparam logic [31:0] mk = 32'h1 << `KEI_SCR_MASKK;
  localparam logic [31:0] ak = 32'h1 << `KEI_SCR_KEY_ACK;
  localparam logic [31:0] kf = 32'h1 << `KEI_SCR_KEY_FLAG;
  localparam logic [31:0] moi = 32'h1 << `KEI_SCR_EXT_SENS;
  localparam logic [31:0] mi = 32'h1 << `KEI_SCR_MASKI;
  localparam logic [31:0] ai = 32'h1 << `KEI_SCR_EXT_ACK;
  localparam logic [31:0] irf = 32'h1 << `KEI_SCR_EXT_FLAG;
  logic mclk, rst_n, psel, penable, pwrite, vfetch, brk, bce, ext_press;
  logic pready, pslverr, slv, ext_pin_n, ext_req, key_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] press, key_pin, port_dir, pullup_en, dir_eff;
  int error_cnt, total_checks, cyc;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  kei_pad_model i_pad (.press(press), .ext_press(ext_press), .key_pin(key_pin),
    .ext_pin_n(ext_pin_n));

  kei_unit i_dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_PIN_N(ext_pin_n), .KEY_PIN(key_pin), .PORT_DIR(port_dir),
    .KEY_PULLUP_EN(pullup_en), .KEY_DIR_EFF(dir_eff), .VECTOR_FETCH(vfetch),
    .BREAK_STATE(brk), .BREAK_CLEAR_ENABLE(bce), .EXT_IRQ_REQ(ext_req),
    .KEY_IRQ_REQ(key_req));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write land before callers look at outputs
    @(posedge mclk);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // hang guard, generous against the roughly 190 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    {psel, penable, pwrite, vfetch, brk, bce, ext_press} = '0;
    paddr = '0;
    pwdata = '0;
    press = '0;
    port_dir = 6'h3f;
    rst_n = 1'b0;
    wt(16);
    rst_n <= 1'b1;
    apb(1'b0, `KEI_ADDR_SCR, 0);
    chk("scr reset", 0, rd);
    apb(1'b0, `KEI_ADDR_KEN, 0);
    chk("ken reset", 0, rd);
    apb(1'b0, 12'h008, 0);
    chk("unmapped slverr", 1, 32'(slv));
    chk("unmapped rdata", 0, rd);
    $display("test reset done");
    apb(1'b1, `KEI_ADDR_SCR, mk);
    apb(1'b1, `KEI_ADDR_KEN, 32'h3f);
    apb(1'b1, `KEI_ADDR_SCR, mk | ak);
    apb(1'b1, `KEI_ADDR_SCR, 0);
    chk("pullups", 32'h3f, 32'(pullup_en));
    chk("dir eff", 0, 32'(dir_eff));
    press <= 6'h01;
    wt(6);
    chk("key req", 1, 32'(key_req));
    apb(1'b1, `KEI_ADDR_SCR, mk);
    chk("key masked", 0, 32'(key_req));
    apb(1'b0, `KEI_ADDR_SCR, 0);
    chk("keypad_pending_flag masked", mk | kf, rd);
    apb(1'b1, `KEI_ADDR_SCR, ak);
    apb(1'b0, `KEI_ADDR_SCR, 0);
    chk("ack edge", 0, rd);
    press <= 6'h03;
    wt(6);
    chk("edge while low", 0, 32'(key_req));
    press <= 6'h00;
    wt(4);
    press <= 6'h02;
    wt(6);
    chk("edge after ack", 1, 32'(key_req));
    $display("test keypad edge done");
    press <= 6'h00;
    apb(1'b1, `KEI_ADDR_SCR, mok | ak);
    press <= 6'h01;
    wt(6);
    apb(1'b1, `KEI_ADDR_SCR, mok | ak);
    wt(1);
    chk("level held", 1, 32'(key_req));
    press <= 6'h00;
    wt(6);
    chk("level released", 0, 32'(key_req));
    press <= 6'h01;
    wt(6);
    press <= 6'h00;
    wt(6);
    chk("wait for ack", 1, 32'(key_req));
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(2);
    chk("reset clears", 0, 32'(key_req));
    $display("test keypad level done");
    apb(1'b1, `KEI_ADDR_KEN, 32'h3f);
    wt(4);
    chk("no false req", 0, 32'(key_req));
    ext_press <= 1'b1;
    wt(6);
    chk("ext req", 1, 32'(ext_req));
    apb(1'b1, `KEI_ADDR_SCR, mi);
    chk("ext masked", 0, 32'(ext_req));
    apb(1'b0, `KEI_ADDR_SCR, 0);
    chk("ext pending", mi | irf, rd);
    apb(1'b1, `KEI_ADDR_SCR, moi | ai);
    apb(1'b0, `KEI_ADDR_SCR, 0);
    chk("ext level held", moi | irf, rd);
    ext_press <= 1'b0;
    wt(6);
    chk("ext released", 0, 32'(ext_req));
    $display("test ext pin done");
    apb(1'b1, `KEI_ADDR_SCR, 0);
    ext_press <= 1'b1;
    press <= 6'h04;
    wt(6);
    brk <= 1'b1;
    apb(1'b1, `KEI_ADDR_SCR, ai | ak);
    wt(1);
    chk("break protect", 2'b11, 32'({ext_req, key_req}));
    bce <= 1'b1;
    apb(1'b1, `KEI_ADDR_SCR, ak);
    brk <= 1'b0;
    wt(2);
    chk("break clear", 2'b10, 32'({ext_req, key_req}));
    press <= 6'h00;
    wt(4);
    press <= 6'h08;
    wt(6);
    @(posedge mclk) vfetch <= 1'b1;
    @(posedge mclk) vfetch <= 1'b0;
    wt(1);
    chk("vector fetch", 0, 32'({ext_req, key_req}));
    $display("test break and fetch done");
    tally_and_finish();
  end
endmodule // keypad_ext_interrupt_unit_tb

`default_nettype wire
